// >>> verilog/sbs_core_regs.svh
// constants for the synchronous burst static ram core
`ifndef SBS_CORE_REGS_SVH
`define SBS_CORE_REGS_SVH

// narrow variant: 4M words, two lanes of nine bits
`define SBS_ADDR_W 22
`define SBS_LANES 2
`define SBS_LANE_W 9

// burst counter width and the low address bits it covers
`define SBS_BURST_W 2
`define SBS_BURST_LSB 0
`define SBS_COUNT_ZERO 2'h0
`define SBS_COUNT_STEP 2'h1

// levels that the internal resistors give a floating mode pin
`define SBS_DEF_FLOW_N 1'b1
`define SBS_DEF_LINEAR_N 1'b1
`define SBS_DEF_SCD_SEL 1'b1

`endif

// >>> verilog/sbs_core_pkg.sv
// types shared by the synchronous burst static ram core
package sbs_core_pkg;

	// access sequencer states, one-hot
	typedef enum logic [2:0]
	{
		SBS_IDLE = 3'h1,
		SBS_BURST = 3'h2,
		SBS_SLEEP = 3'h4
	} sbs_state_t;

endpackage

// >>> verilog/sbs_core.sv
// synchronous burst static ram core with burst counter and deselect modes
//
`timescale 1ns/1ps
`include "sbs_core_regs.svh"
// Notes on behaviour
// - controls and data captured on rising clock only
// - output enable and sleep act without clock
// - either address strobe loads the burst counter
// - later addresses internal, step only on advance
// - two-bit counter on the two lowest bits
// - order select picks linear or interleaved stepping
// - fresh address may come every single cycle
// - flow-through low bypasses the output register
// - flow-through high registers data, one more cycle
// - single-cycle deselect turns outputs off one stage early
// - dual-cycle deselect is pipelined like a read
// - deselect mode input picks single or dual
// - floating mode pins give single, interleaved, pipelined
// - byte write writes only the selected lanes
// - global write writes all lanes regardless
// - writes complete inside the device on the edge
// - sleep on request high only
// - contents kept through sleep and readable after
// - 4M by 18 narrow or 2M by 36 wide
// - order select low linear, high interleaved
// - advance low on an edge steps the counter
// - selected when second enable high, others low
module sbs_core
#(
	parameter int ADDR_W = `SBS_ADDR_W,
	parameter int LANES = `SBS_LANES,
	parameter int LANE_W = `SBS_LANE_W
)
(
	input wire logic i_ref_clk,
	input wire logic i_srst,
	input wire logic [ADDR_W-1:0] i_addr,
	input wire logic [LANES*LANE_W-1:0] i_dq,
	output logic [LANES*LANE_W-1:0] o_dq,
	output logic o_dq_oe,
	input wire logic i_chip_sel_first_n,
	input wire logic i_chip_sel_second,
	input wire logic i_chip_sel_third_n,
	input wire logic i_proc_addr_strobe_n,
	input wire logic i_ctrl_addr_strobe_n,
	input wire logic i_burst_advance_n,
	input wire logic [LANES-1:0] i_byte_lane_select_n,
	input wire logic i_byte_write_enable_n,
	input wire logic i_global_write_n,
	input wire logic i_out_enable_n,
	input wire logic i_sleep_request,
	input wire logic i_flow_through_select_n,
	input wire logic i_linear_order_select_n,
	input wire logic i_deselect_mode_select,
	output logic o_sleep_active
);

	localparam int DATA_W = LANES * LANE_W;
	localparam int BW = `SBS_BURST_W;
	localparam int DEPTH = 1 << ADDR_W;

	// low address bits of a burst beat from start bits and beat count
	function automatic logic [BW-1:0] burst_lo
	(
		input logic [BW-1:0] start,
		input logic [BW-1:0] count,
		input logic linear
	);
		if (linear)
		begin
			burst_lo = BW'(start + count);
		end
		else
		begin
			burst_lo = start ^ count;
		end
	endfunction

	// lanes written by a cycle, all of them under a global write
	function automatic logic [LANES-1:0] lane_mask
	(
		input logic global_n,
		input logic byte_en_n,
		input logic [LANES-1:0] sel_n
	);
		if (!global_n)
		begin
			lane_mask = {LANES{1'b1}};
		end
		else if (!byte_en_n)
		begin
			lane_mask = ~sel_n;
		end
		else
		begin
			lane_mask = {LANES{1'b0}};
		end
	endfunction

	// array kept in flip-flops, never reset
	logic [DATA_W-1:0] mem [0:DEPTH-1];

	// mode pin and sleep synchronisers
	logic sleep_meta;
	logic sleep_sync;
	logic flow_meta;
	logic flow_sync_n;
	logic linear_meta;
	logic linear_sync_n;
	logic scd_meta;
	logic scd_sync;

	sbs_core_pkg::sbs_state_t state;
	sbs_core_pkg::sbs_state_t next_state;

	logic [ADDR_W-1:0] base_addr;
	logic [BW-1:0] count;
	logic [BW-1:0] next_count;
	logic [ADDR_W-1:0] acc_addr;
	logic [ADDR_W-1:0] rd_addr;
	logic read_q;
	logic flow_drive;
	logic pipe_drive;
	logic [DATA_W-1:0] out_reg;

	logic selected;
	logic strobe;
	logic start_cmd;
	logic desel_cmd;
	logic cont_cmd;
	logic access;
	logic [LANES-1:0] wr_lanes;
	logic is_write;
	logic is_read;
	logic flow_mode;
	logic linear_mode;
	logic dual_cycle_deselect;
	logic drive_now;

	// sleep pin caught twice before the sequencer uses it
	always_ff @(posedge i_ref_clk)
	begin
		if (i_srst)
		begin
			sleep_meta <= 1'b0;
			sleep_sync <= 1'b0;
		end
		else
		begin
			sleep_meta <= i_sleep_request;
			sleep_sync <= sleep_meta;
		end
	end

	// mode pins reset to the floating-pin defaults
	always_ff @(posedge i_ref_clk)
	begin
		if (i_srst)
		begin
			flow_meta <= `SBS_DEF_FLOW_N;
			flow_sync_n <= `SBS_DEF_FLOW_N;
			linear_meta <= `SBS_DEF_LINEAR_N;
			linear_sync_n <= `SBS_DEF_LINEAR_N;
			scd_meta <= `SBS_DEF_SCD_SEL;
			scd_sync <= `SBS_DEF_SCD_SEL;
		end
		else
		begin
			flow_meta <= i_flow_through_select_n;
			flow_sync_n <= flow_meta;
			linear_meta <= i_linear_order_select_n;
			linear_sync_n <= linear_meta;
			scd_meta <= i_deselect_mode_select;
			scd_sync <= scd_meta;
		end
	end

	// flow-through while the select pin is low
	assign flow_mode = ~flow_sync_n;
	assign linear_mode = ~linear_sync_n;
	// deselect mode input low selects dual-cycle
	assign dual_cycle_deselect = ~scd_sync;

	// three chip enables decode the selection
	assign selected = ~i_chip_sel_first_n & i_chip_sel_second &
		~i_chip_sel_third_n;
	// either strobe starts a new access
	assign strobe = ~i_proc_addr_strobe_n | ~i_ctrl_addr_strobe_n;
	assign start_cmd = strobe & selected & ~sleep_sync;
	assign desel_cmd = strobe & ~selected & ~sleep_sync;
	assign cont_cmd = ~strobe & (state == sbs_core_pkg::SBS_BURST) &
		~sleep_sync;
	// a strobe on every cycle is taken with no stall
	assign access = start_cmd | cont_cmd;

	// byte write takes only the selected lanes
	// global write overrides the byte controls
	assign wr_lanes = lane_mask(i_global_write_n, i_byte_write_enable_n,
		i_byte_lane_select_n);
	assign is_write = access & (|wr_lanes);
	assign is_read = access & ~(|wr_lanes);

	always_comb
	begin
		next_count = count;
		if (start_cmd)
		begin
			next_count = `SBS_COUNT_ZERO;
		end
		// advance low on this edge steps the counter
		else if (cont_cmd && !i_burst_advance_n)
		begin
			next_count = BW'(count + `SBS_COUNT_STEP);
		end
	end

	always_comb
	begin
		acc_addr = base_addr;
		if (start_cmd)
		begin
			acc_addr = i_addr;
		end
		else
		begin
			// interleave by xor, linear by add
			acc_addr[`SBS_BURST_LSB +: BW] = burst_lo(
				base_addr[`SBS_BURST_LSB +: BW], next_count, linear_mode);
		end
	end

	always_comb
	begin
		next_state = state;
		unique case (state)
			sbs_core_pkg::SBS_IDLE:
			begin
				if (start_cmd)
				begin
					next_state = sbs_core_pkg::SBS_BURST;
				end
			end
			sbs_core_pkg::SBS_BURST:
			begin
				if (desel_cmd)
				begin
					next_state = sbs_core_pkg::SBS_IDLE;
				end
			end
			sbs_core_pkg::SBS_SLEEP:
			begin
				next_state = sbs_core_pkg::SBS_IDLE;
			end
			default:
			begin
				next_state = sbs_core_pkg::SBS_IDLE;
			end
		endcase
		if (sleep_sync)
		begin
			next_state = sbs_core_pkg::SBS_SLEEP;
		end
	end

	// all synchronous inputs sampled on the rising edge
	always_ff @(posedge i_ref_clk)
	begin
		if (i_srst)
		begin
			state <= sbs_core_pkg::SBS_IDLE;
		end
		else
		begin
			state <= next_state;
		end
	end

	// strobe loads the external address into the counter
	// counter spans the two lowest address bits
	always_ff @(posedge i_ref_clk)
	begin
		if (i_srst)
		begin
			base_addr <= '0;
			count <= `SBS_COUNT_ZERO;
		end
		else
		begin
			if (start_cmd)
			begin
				base_addr <= i_addr;
			end
			count <= next_count;
		end
	end

	// write completes on the capturing edge
	// array untouched by sleep and reset
	always_ff @(posedge i_ref_clk)
	begin
		if (is_write && !i_srst)
		begin
			for (int l = 0; l < LANES; l++)
			begin
				if (wr_lanes[l])
				begin
					mem[acc_addr][l*LANE_W +: LANE_W] <=
						i_dq[l*LANE_W +: LANE_W];
				end
			end
		end
	end

	// read address held for the flow path and the output register
	always_ff @(posedge i_ref_clk)
	begin
		if (i_srst)
		begin
			rd_addr <= '0;
		end
		else if (is_read)
		begin
			rd_addr <= acc_addr;
		end
	end

	// dual-cycle holds the flow drive one more cycle
	always_ff @(posedge i_ref_clk)
	begin
		if (i_srst || sleep_sync)
		begin
			read_q <= 1'b0;
			flow_drive <= 1'b0;
		end
		else
		begin
			read_q <= is_read;
			flow_drive <= is_read |
				(dual_cycle_deselect & desel_cmd & read_q);
		end
	end

	// output register adds one cycle of latency
	always_ff @(posedge i_ref_clk)
	begin
		out_reg <= mem[rd_addr];
	end

	// single-cycle deselect drops the drive on capture
	// dual-cycle lets the pipeline drain normally
	always_ff @(posedge i_ref_clk)
	begin
		if (i_srst || sleep_sync)
		begin
			pipe_drive <= 1'b0;
		end
		else
		begin
			pipe_drive <= read_q & ~(~dual_cycle_deselect & desel_cmd);
		end
	end

	// sleep state reported from a flip-flop
	always_ff @(posedge i_ref_clk)
	begin
		if (i_srst)
		begin
			o_sleep_active <= 1'b0;
		end
		else
		begin
			o_sleep_active <= sleep_sync;
		end
	end

	// flow-through reads the array straight to the pins
	// pipelined mode shows the output register
	always_comb
	begin
		if (flow_mode)
		begin
			o_dq = mem[rd_addr];
			drive_now = flow_drive;
		end
		else
		begin
			o_dq = out_reg;
			drive_now = pipe_drive;
		end
	end

	// output enable and sleep gate the pins with no clock
	// output enable high turns the pins off
	assign o_dq_oe = drive_now & ~i_out_enable_n & ~i_sleep_request;

endmodule

// >>> verif/sbs_core_assertions.sv
// port checker for the burst static ram core
`timescale 1ns/1ps
module sbs_core_assertions
(
	input wire logic i_ref_clk,
	input wire logic i_srst,
	input wire logic o_dq_oe,
	input wire logic i_chip_sel_first_n,
	input wire logic i_chip_sel_second,
	input wire logic i_chip_sel_third_n,
	input wire logic i_proc_addr_strobe_n,
	input wire logic i_ctrl_addr_strobe_n,
	input wire logic i_byte_write_enable_n,
	input wire logic i_global_write_n,
	input wire logic i_out_enable_n,
	input wire logic i_sleep_request,
	input wire logic i_flow_through_select_n,
	input wire logic i_deselect_mode_select,
	input wire logic o_sleep_active
);
	logic [2:0] ft;
	logic [2:0] sc;
	logic [2:0] zz;
	wire logic st = !i_proc_addr_strobe_n || !i_ctrl_addr_strobe_n;
	wire logic aw = zz == 3'h0 && !i_sleep_request;
	wire logic ok = !i_out_enable_n && !i_sleep_request;
	wire logic sel = !i_chip_sel_first_n && i_chip_sel_second &&
		!i_chip_sel_third_n;
	wire logic sl = st && sel && aw;
	wire logic ds = st && !sel && aw;
	wire logic wr = sl && !i_global_write_n;
	wire logic rd = sl && i_global_write_n && i_byte_write_enable_n;
	wire logic md_ft = ft == 3'h0 && !i_flow_through_select_n;
	wire logic md_pl = ft == 3'h7 && i_flow_through_select_n;
	wire logic md_s = sc == 3'h7 && i_deselect_mode_select;
	wire logic md_d = sc == 3'h0 && !i_deselect_mode_select;
	default clocking dc @(posedge i_ref_clk);
	endclocking
	default disable iff (i_srst);
	// pin history, preset to the synchronisers' reset defaults
	always_ff @(posedge i_ref_clk)
	begin
		if (i_srst)
		begin
			ft <= 3'h7;
			sc <= 3'h7;
			zz <= 3'h0;
		end
		else
		begin
			ft <= {ft[1:0], i_flow_through_select_n};
			sc <= {sc[1:0], i_deselect_mode_select};
			zz <= {zz[1:0], i_sleep_request};
		end
	end
	a_oe_forced_off: assert property (i_out_enable_n |-> !o_dq_oe)
		else $error("drive on with output enable off");
	a_sleep_pins_off: assert property (i_sleep_request |-> !o_dq_oe)
		else $error("drive on during sleep request");
	a_sleep_entry: assert property (
		i_sleep_request [*3] |=> o_sleep_active)
		else $error("sleep flag late");
	a_write_drops: assert property (md_ft && wr |=> !o_dq_oe)
		else $error("drive after write");
	// pipelined: an earlier read may still show for one cycle
	a_pipe_write_off: assert property (
		md_pl && wr |=> ##1 !o_dq_oe)
		else $error("pipelined drive after write");
	a_scd_off: assert property (md_s && ds |=> !o_dq_oe)
		else $error("single deselect late");
	a_dcd_off: assert property (md_d && ds ##1 !st |=> !o_dq_oe)
		else $error("dual deselect late");
	a_flow_read: assert property (md_ft && rd ##1 ok |-> o_dq_oe)
		else $error("flow read not driven");
	a_pipe_read: assert property (
		md_pl && rd ##1 ok && !st ##1 ok |-> o_dq_oe)
		else $error("pipelined read not driven");
	c_pipe: cover property (md_pl && rd);
	c_desel: cover property (ds);
	c_sleep: cover property (o_sleep_active);
endmodule
bind sbs_core sbs_core_assertions chk (.i_ref_clk, .i_srst, .o_dq_oe,
	.i_chip_sel_first_n, .i_chip_sel_third_n,
	.i_chip_sel_second, .i_proc_addr_strobe_n, .i_ctrl_addr_strobe_n,
	.i_byte_write_enable_n, .i_global_write_n, .i_out_enable_n,
	.i_sleep_request, .i_flow_through_select_n, .i_deselect_mode_select,
	.o_sleep_active);

// >>> verif/sbs_ctrl_model.sv
// controller model driving the synchronous burst ram bus
`timescale 1ns/1ps
module sbs_ctrl_model
(
	input wire logic i_ref_clk,
	output logic [21:0] o_addr,
	output logic [17:0] o_dq,
	output logic o_chip_sel_second,
	output logic o_proc_addr_strobe_n,
	output logic o_ctrl_addr_strobe_n,
	output logic o_burst_advance_n,
	output logic [1:0] o_byte_lane_select_n,
	output logic o_byte_write_enable_n,
	output logic o_global_write_n
);
	initial
	begin
		{o_addr, o_dq} = '0;
		{o_chip_sel_second, o_proc_addr_strobe_n, o_ctrl_addr_strobe_n,
			o_burst_advance_n, o_byte_lane_select_n,
			o_byte_write_enable_n, o_global_write_n} = '1;
	end
	// c: 0 idle, 1 read, 2 global write, 3 lane0 write, 4 step, 5 deselect
	task automatic op(input logic [2:0] c, input logic [21:0] a,
		input logic [17:0] d);
		@(posedge i_ref_clk);
		o_addr <= a;
		o_dq <= c == 3'h2 || c == 3'h3 ? d : ~o_dq;
		o_proc_addr_strobe_n <= c != 3'h1;
		o_ctrl_addr_strobe_n <= !(c == 3'h2 || c == 3'h3 || c == 3'h5);
		o_chip_sel_second <= c != 3'h5;
		o_burst_advance_n <= c != 3'h4;
		o_global_write_n <= c != 3'h2;
		o_byte_write_enable_n <= c != 3'h3;
		o_byte_lane_select_n <= c == 3'h3 ? 2'h2 : 2'h3;
	endtask
endmodule

// >>> verif/tb_top.sv
// self-checking bench for the burst static ram core
`timescale 1ns/1ps
module tb_top;
	logic i_ref_clk = 1'b0;
	logic i_srst = 1'b1;
	logic [21:0] i_addr;
	logic [17:0] i_dq;
	logic [17:0] o_dq;
	logic o_dq_oe;
	logic i_chip_sel_first_n = 1'b0;
	logic i_chip_sel_second;
	logic i_chip_sel_third_n = 1'b0;
	logic i_proc_addr_strobe_n;
	logic i_ctrl_addr_strobe_n;
	logic i_burst_advance_n;
	logic [1:0] i_byte_lane_select_n;
	logic i_byte_write_enable_n;
	logic i_global_write_n;
	logic i_out_enable_n = 1'b0;
	logic i_sleep_request = 1'b0;
	logic i_flow_through_select_n = 1'b1;
	logic i_linear_order_select_n = 1'b1;
	logic i_deselect_mode_select = 1'b1;
	logic o_sleep_active;
	logic [17:0] ram [8];
	int n_errors = 0;
	int n_checks = 0;
	always #2.5 i_ref_clk = ~i_ref_clk;
	sbs_core dut (.i_ref_clk, .i_srst, .i_addr, .i_dq, .o_dq, .o_dq_oe,
		.i_chip_sel_first_n, .i_chip_sel_second, .i_chip_sel_third_n,
		.i_proc_addr_strobe_n, .i_ctrl_addr_strobe_n, .i_burst_advance_n,
		.i_byte_lane_select_n, .i_byte_write_enable_n, .i_global_write_n,
		.i_out_enable_n, .i_sleep_request, .i_flow_through_select_n,
		.i_linear_order_select_n, .i_deselect_mode_select, .o_sleep_active);
	sbs_ctrl_model m (.i_ref_clk, .o_addr(i_addr), .o_dq(i_dq),
		.o_chip_sel_second(i_chip_sel_second),
		.o_proc_addr_strobe_n(i_proc_addr_strobe_n),
		.o_ctrl_addr_strobe_n(i_ctrl_addr_strobe_n),
		.o_burst_advance_n(i_burst_advance_n),
		.o_byte_lane_select_n(i_byte_lane_select_n),
		.o_byte_write_enable_n(i_byte_write_enable_n),
		.o_global_write_n(i_global_write_n));
	task automatic chk(input logic cd, input logic [17:0] e,
		input logic oe, input logic sl);
		n_checks++;
		if ((cd && o_dq !== e) || o_dq_oe !== oe || o_sleep_active !== sl)
		begin
			n_errors++;
			$display("ERROR %0t dq %h oe %b sleep %b want %h %b %b",
				$time, o_dq, o_dq_oe, o_sleep_active, e, oe, sl);
		end
	endtask
	// lat 0 flow-through, 1 pipelined; beats follow the order select
	task automatic rd_burst(input logic [2:0] a, input logic lin,
		input int lat);
		int k;
		logic [1:0] b;
		for (int j = 0; j < 6; j++)
		begin
			m.op(j == 0 ? 3'h1 : (j < 4 ? 3'h4 : 3'h0), {19'h0, a}, 18'h0);
			#1;
			k = j - 1 - lat;
			b = lin ? a[1:0] + k[1:0] : a[1:0] ^ k[1:0];
			if (k >= 0 && k < 4)
				chk(1'b1, ram[{a[2], b}], 1'b1, 1'b0);
		end
	endtask
	task automatic idle3;
		repeat (3) m.op(3'h0, 22'h0, 18'h0);
	endtask
	task tally_and_finish;
		$display("checks %0d errors %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	initial
	begin
		#5000;
		n_errors++;
		tally_and_finish;
	end
	initial
	begin
		repeat (4) @(posedge i_ref_clk);
		i_srst <= 1'b0;
		for (int i = 0; i < 8; i++)
		begin
			ram[i] = 18'h2A500 ^ 18'(i);
			m.op(3'h2, 22'(i), ram[i]);
		end
		m.op(3'h3, 22'h5, 18'h3FFFF);
		ram[5][8:0] = 9'h1FF;
		rd_burst(3'h5, 1'b0, 1);
		@(posedge i_ref_clk) i_linear_order_select_n <= 1'b0;
		idle3;
		rd_burst(3'h6, 1'b1, 1);
		@(posedge i_ref_clk) i_flow_through_select_n <= 1'b0;
		idle3;
		rd_burst(3'h1, 1'b1, 0);
		@(posedge i_ref_clk) i_flow_through_select_n <= 1'b1;
		for (int s = 1; s >= 0; s--)
		begin
			@(posedge i_ref_clk) i_deselect_mode_select <= s[0];
			idle3;
			m.op(3'h1, 22'h3, 18'h0);
			m.op(3'h5, 22'h0, 18'h0);
			m.op(3'h0, 22'h0, 18'h0);
			#1 chk(!s[0], ram[3], !s[0], 1'b0);
			m.op(3'h0, 22'h0, 18'h0);
			#1 chk(1'b0, 18'h0, 1'b0, 1'b0);
		end
		m.op(3'h1, 22'h2, 18'h0);
		m.op(3'h0, 22'h0, 18'h0);
		m.op(3'h0, 22'h0, 18'h0);
		#1 chk(1'b1, ram[2], 1'b1, 1'b0);
		@(posedge i_ref_clk) i_out_enable_n <= 1'b1;
		#1 chk(1'b0, 18'h0, 1'b0, 1'b0);
		@(posedge i_ref_clk) i_out_enable_n <= 1'b0;
		#1 chk(1'b1, ram[2], 1'b1, 1'b0);
		@(posedge i_ref_clk) i_sleep_request <= 1'b1;
		#1 chk(1'b0, 18'h0, 1'b0, 1'b0);
		idle3;
		#1 chk(1'b0, 18'h0, 1'b0, 1'b1);
		m.op(3'h2, 22'h2, 18'h15555);
		m.op(3'h0, 22'h0, 18'h0);
		i_sleep_request <= 1'b0;
		idle3;
		rd_burst(3'h2, 1'b1, 1);
		// a strobe with the first or third enable off is a deselect
		for (int c = 0; c < 2; c++)
		begin
			@(posedge i_ref_clk)
			begin
				i_chip_sel_first_n <= c == 0;
				i_chip_sel_third_n <= c == 1;
			end
			m.op(3'h1, 22'h2, 18'h0);
			m.op(3'h0, 22'h0, 18'h0);
			m.op(3'h0, 22'h0, 18'h0);
			#1 chk(1'b0, 18'h0, 1'b0, 1'b0);
		end
		// flow-through with dual-cycle deselect holds one more cycle
		@(posedge i_ref_clk)
		begin
			i_chip_sel_third_n <= 1'b0;
			i_flow_through_select_n <= 1'b0;
		end
		idle3;
		ram[4] = 18'h0ABCD;
		m.op(3'h2, 22'h4, ram[4]);
		m.op(3'h1, 22'h4, 18'h0);
		m.op(3'h5, 22'h0, 18'h0);
		m.op(3'h0, 22'h0, 18'h0);
		#1 chk(1'b1, ram[4], 1'b1, 1'b0);
		m.op(3'h0, 22'h0, 18'h0);
		#1 chk(1'b0, 18'h0, 1'b0, 1'b0);
		tally_and_finish;
	end
endmodule
